// ===== core/bcs_brake_seq.sv
// Purpose: brake release/engage sequencer for a motor drive
// Assumes: inputs synchronous to clk; run_cmd is a level, low means stop
// Notes:   brake level 1 = released on each output coded for brake control
`timescale 1ns/1ps
`default_nettype none

module bcs_brake_seq
  import bcs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [DW-1:0] rdata,
  input  wire logic          run_cmd,
  input  wire logic          dir_reverse,
  input  wire logic [15:0]   out_freq,
  input  wire logic [15:0]   motor_current,
  output bcs_drive_t         drive_cmd,
  output logic      [15:0]   freq_target,
  output logic               relay_one,
  output logic               relay_two,
  output logic               transistor_output_one,
  output logic               suppress_dc_start,
  output logic               suppress_dwell
);

  logic              brake_en_ff;
  logic       [2:0]  mode_ff;
  logic              torque_ff;
  logic       [15:0] release_current_threshold_ff;
  logic       [15:0] release_hold_delay_ff;
  logic       [15:0] release_freq_forward_ff;
  logic       [15:0] release_freq_reverse_ff;
  logic       [15:0] engage_hold_delay_ff;
  logic       [15:0] engage_frequency_ff;
  logic       [23:0] brake_output_function_ff;
  logic       [15:0] preexc_time_ff;
  logic       [15:0] dcb_time_ff;
  logic       [15:0] dcb_level_ff;

  bcs_state_t        state_ff;
  bcs_state_t        nxt_state;
  logic              rev_ff;
  logic       [31:0] presc_ff;
  logic       [15:0] dly_ff;
  logic       [15:0] nxt_dly;
  logic              brake_rel_ff;
  logic              nxt_brake_rel;
  bcs_drive_t        drive_ff;
  bcs_drive_t        nxt_drive;
  logic       [15:0] target_ff;
  logic       [15:0] nxt_target;
  logic       [DW-1:0] rdata_ff;
  logic       [DW-1:0] nxt_rdata;
  logic              relay_one_ff;
  logic              relay_two_ff;
  logic              q1_ff;
  logic              sup_ff;

  // write decode with range clamping of mode, current, delay and frequency values
  wire        wr_ctrl  = wr_stb && (addr == ADDR_CTRL);
  wire [15:0] wd16     = wdata[15:0];
  wire [2:0]  wr_mode  = (wdata[CTRL_MODE_LSB +: 3] > MODE_MAX) ? MODE_MAX : wdata[CTRL_MODE_LSB +: 3];
  wire [15:0] wd_curr  = (wd16 > REL_CURR_MAX) ? REL_CURR_MAX : wd16;
  wire [15:0] wd_dly   = (wd16 > DLY_MAX) ? DLY_MAX : wd16;
  wire [15:0] wd_frq   = (wd16 > FRQ_MAX) ? FRQ_MAX : wd16;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      brake_en_ff                  <= 1'b0;
      mode_ff                      <= 3'h0;
      torque_ff                    <= 1'b0;
      release_current_threshold_ff <= REL_CURR_RST;
      release_hold_delay_ff        <= REL_DLY_RST;
      release_freq_forward_ff      <= REL_FRQ_RST;
      release_freq_reverse_ff      <= REL_FRQ_RST;
      engage_hold_delay_ff         <= ENG_DLY_RST;
      engage_frequency_ff          <= ENG_FRQ_RST;
      brake_output_function_ff     <= 24'h00_0000;
      preexc_time_ff               <= ZERO16;
      dcb_time_ff                  <= ZERO16;
      dcb_level_ff                 <= ZERO16;
    end else if (wr_stb) begin
      if (wr_ctrl) begin
        brake_en_ff <= wdata[CTRL_EN_BIT];
        mode_ff     <= wr_mode;
        torque_ff   <= wdata[CTRL_TORQ_BIT];
      end
      if (addr == ADDR_REL_CURR) release_current_threshold_ff <= wd_curr;
      if (addr == ADDR_REL_DLY)  release_hold_delay_ff        <= wd_dly;
      if (addr == ADDR_REL_FWD)  release_freq_forward_ff      <= wd_frq;
      if (addr == ADDR_REL_REV)  release_freq_reverse_ff      <= wd_frq;
      if (addr == ADDR_ENG_DLY)  engage_hold_delay_ff         <= wd_dly;
      if (addr == ADDR_ENG_FREQ) engage_frequency_ff          <= wd_frq;
      if (addr == ADDR_OUT_FUNC) brake_output_function_ff     <= wdata[23:0];
      if (addr == ADDR_PREEXC)   preexc_time_ff               <= wd16;
      if (addr == ADDR_DCB_TIME) dcb_time_ff                  <= wd16;
      if (addr == ADDR_DCB_LVL)  dcb_level_ff                 <= wd16;
    end
  end

  // read path: data stands only in the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (rd_stb) begin
      case (addr)
        ADDR_CTRL:     nxt_rdata = {27'h000_0000, torque_ff, mode_ff, brake_en_ff};
        ADDR_REL_CURR: nxt_rdata = {16'h0000, release_current_threshold_ff};
        ADDR_REL_DLY:  nxt_rdata = {16'h0000, release_hold_delay_ff};
        ADDR_REL_FWD:  nxt_rdata = {16'h0000, release_freq_forward_ff};
        ADDR_REL_REV:  nxt_rdata = {16'h0000, release_freq_reverse_ff};
        ADDR_ENG_DLY:  nxt_rdata = {16'h0000, engage_hold_delay_ff};
        ADDR_ENG_FREQ: nxt_rdata = {16'h0000, engage_frequency_ff};
        ADDR_OUT_FUNC: nxt_rdata = {8'h00, brake_output_function_ff};
        ADDR_PREEXC:   nxt_rdata = {16'h0000, preexc_time_ff};
        ADDR_DCB_TIME: nxt_rdata = {16'h0000, dcb_time_ff};
        ADDR_DCB_LVL:  nxt_rdata = {16'h0000, dcb_level_ff};
        ADDR_STATUS:   nxt_rdata = {16'h0000, 11'h000, brake_rel_ff, state_ff};
        default:       nxt_rdata = '0;
      endcase
    end
  end

  // delay time base: one tick each 0.01 s
  wire tick = (presc_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) presc_ff <= 32'h0000_0000;
    else         presc_ff <= tick ? 32'h0000_0000 : presc_ff + 32'h0000_0001;
  end

  wire is_vector   = (mode_ff == MODE_VECTOR);
  wire [15:0] rel_target = rev_ff ? release_freq_reverse_ff : release_freq_forward_ff;
  wire dly_done    = (dly_ff == ZERO16);
  wire dly_step    = tick && !dly_done;
  wire dcb_on      = (dcb_time_ff != ZERO16) && (dcb_level_ff != ZERO16);
  wire at_rel_freq = (out_freq >= rel_target);
  wire cur_ok      = (motor_current >= release_current_threshold_ff);
  wire at_eng_freq = (out_freq <= engage_frequency_ff);
  wire at_zero     = (out_freq == ZERO16);
  wire stop_req    = !run_cmd;

  always_comb begin
    nxt_state     = state_ff;
    nxt_dly       = dly_step ? dly_ff - ONE16 : dly_ff;
    nxt_brake_rel = brake_rel_ff;
    nxt_target    = target_ff;
    nxt_drive     = DRV_BLOCK;
    case (state_ff)
      ST_IDLE: begin
        nxt_brake_rel = 1'b0;
        if (!brake_en_ff) begin
          nxt_drive = '{default: 1'b0, accel_en: run_cmd, decel_en: !run_cmd, out_block: 1'b0};
        end else if (run_cmd && is_vector) begin
          nxt_state = ST_PREEXC;
          nxt_dly   = preexc_time_ff;
        end else if (run_cmd) begin
          nxt_state = ST_ACC_REL;
        end
      end
      ST_PREEXC: begin
        nxt_drive = '{default: 1'b0, pre_excite: 1'b1, hold_freq: 1'b1};
        if (stop_req) begin
          nxt_state = ST_IDLE;
        end else if (dly_done) begin
          nxt_state     = ST_REL_HOLD;
          nxt_brake_rel = 1'b1;
          nxt_dly       = release_hold_delay_ff;
        end
      end
      ST_ACC_REL: begin
        nxt_target = rel_target;
        nxt_drive  = '{default: 1'b0, accel_en: !at_rel_freq, hold_freq: at_rel_freq};
        if (stop_req)         nxt_state = ST_IDLE;
        else if (at_rel_freq) nxt_state = ST_WAIT_CUR;
      end
      ST_WAIT_CUR: begin
        nxt_drive = '{default: 1'b0, hold_freq: 1'b1};
        if (stop_req) begin
          nxt_state = ST_IDLE;
        end else if (cur_ok) begin
          nxt_state     = ST_REL_HOLD;
          nxt_brake_rel = 1'b1;
          nxt_dly       = release_hold_delay_ff;
        end
      end
      ST_REL_HOLD: begin
        nxt_drive = '{default: 1'b0, hold_freq: 1'b1};
        if (stop_req)      nxt_state = ST_DECEL;
        else if (dly_done) nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_drive = '{default: 1'b0, accel_en: 1'b1};
        if (stop_req) nxt_state = (is_vector && torque_ff) ? ST_PLAIN_STOP : ST_DECEL;
      end
      ST_DECEL: begin
        nxt_target = is_vector ? ZERO16 : engage_frequency_ff;
        nxt_drive  = '{default: 1'b0, decel_en: 1'b1};
        if (run_cmd) begin
          nxt_state = ST_RUN;
        end else if (is_vector ? at_zero : at_eng_freq) begin
          // ramp stops in the same cycle the brake engages
          nxt_drive     = '{default: 1'b0, hold_freq: 1'b1};
          nxt_state     = ST_ENG_HOLD;
          nxt_brake_rel = 1'b0;
          nxt_dly       = engage_hold_delay_ff;
        end
      end
      ST_ENG_HOLD: begin
        nxt_drive = '{default: 1'b0, hold_freq: 1'b1};
        if (dly_done) begin
          if (!is_vector && dcb_on) begin
            nxt_state = ST_DC_BRAKE;
            nxt_dly   = dcb_time_ff;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_DC_BRAKE: begin
        nxt_drive = '{default: 1'b0, force_zero: 1'b1, dc_brake: 1'b1};
        if (dly_done) nxt_state = ST_IDLE;
      end
      ST_PLAIN_STOP: begin
        nxt_drive = '{default: 1'b0, decel_en: 1'b1};
        if (at_zero) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    // force zero once engage hold ends, whichever way it leaves
    if (state_ff == ST_ENG_HOLD && dly_done) nxt_drive.force_zero = 1'b1;
  end

  // brake level routed to each output coded for brake control
  wire [2:0] func_sel;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_func
      assign func_sel[g] = (brake_output_function_ff[g*8 +: 8] == FUNC_BRAKE);
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= ST_IDLE;
      dly_ff       <= ZERO16;
      rev_ff       <= 1'b0;
      brake_rel_ff <= 1'b0;
      drive_ff     <= DRV_BLOCK;
      target_ff    <= ZERO16;
      rdata_ff     <= '0;
      relay_one_ff <= 1'b0;
      relay_two_ff <= 1'b0;
      q1_ff        <= 1'b0;
      sup_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      dly_ff       <= nxt_dly;
      rev_ff       <= (state_ff == ST_IDLE) ? dir_reverse : rev_ff;
      brake_rel_ff <= nxt_brake_rel;
      drive_ff     <= nxt_drive;
      target_ff    <= nxt_target;
      rdata_ff     <= nxt_rdata;
      relay_one_ff <= func_sel[0] && nxt_brake_rel;
      relay_two_ff <= func_sel[1] && nxt_brake_rel;
      q1_ff        <= func_sel[2] && nxt_brake_rel;
      sup_ff       <= brake_en_ff;
    end
  end

  assign rdata                 = rdata_ff;
  assign drive_cmd             = drive_ff;
  assign freq_target           = target_ff;
  assign relay_one             = relay_one_ff;
  assign relay_two             = relay_two_ff;
  assign transistor_output_one = q1_ff;
  assign suppress_dc_start     = sup_ff;
  assign suppress_dwell        = sup_ff;

endmodule : bcs_brake_seq

`default_nettype wire

// ===== core/bcs_pkg.sv
// Purpose: shared constants and types for the brake control sequencer
// Assumes: 20 MHz clock, frequencies in 0.01 Hz, current in 0.1 %, delays in 0.01 s
// Notes:   register offsets are byte addresses of aligned 32-bit words
package bcs_pkg;

  localparam int CLK_NS      = 50;
  localparam int TICK_NS     = 10_000_000;            // delay resolution 0.01 s
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  localparam int AW = 8;
  localparam int DW = 32;

  localparam logic [AW-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [AW-1:0] ADDR_REL_CURR = 8'h04;
  localparam logic [AW-1:0] ADDR_REL_DLY  = 8'h08;
  localparam logic [AW-1:0] ADDR_REL_FWD  = 8'h0C;
  localparam logic [AW-1:0] ADDR_REL_REV  = 8'h10;
  localparam logic [AW-1:0] ADDR_ENG_DLY  = 8'h14;
  localparam logic [AW-1:0] ADDR_ENG_FREQ = 8'h18;
  localparam logic [AW-1:0] ADDR_OUT_FUNC = 8'h1C;
  localparam logic [AW-1:0] ADDR_PREEXC   = 8'h20;
  localparam logic [AW-1:0] ADDR_DCB_TIME = 8'h24;
  localparam logic [AW-1:0] ADDR_DCB_LVL  = 8'h28;
  localparam logic [AW-1:0] ADDR_STATUS   = 8'h2C;

  // control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_TORQ_BIT = 4;

  // output function register fields: one code byte per output
  localparam int FUNC_R1_LSB = 0;
  localparam int FUNC_R2_LSB = 8;
  localparam int FUNC_Q1_LSB = 16;

  localparam logic [2:0]  MODE_VECTOR  = 3'h5;
  localparam logic [2:0]  MODE_MAX     = 3'h5;
  localparam logic [7:0]  FUNC_BRAKE   = 8'h23;       // function code 35

  localparam logic [15:0] REL_CURR_RST = 16'h01F4;    // 50.0 %
  localparam logic [15:0] REL_CURR_MAX = 16'h0708;    // 180.0 %
  localparam logic [15:0] REL_DLY_RST  = 16'h0064;    // 1.00 s
  localparam logic [15:0] ENG_DLY_RST  = 16'h0064;    // 1.00 s
  localparam logic [15:0] DLY_MAX      = 16'h03E8;    // 10.00 s
  localparam logic [15:0] REL_FRQ_RST  = 16'h0064;    // 1.00 Hz
  localparam logic [15:0] ENG_FRQ_RST  = 16'h00C8;    // 2.00 Hz
  localparam logic [15:0] FRQ_MAX      = 16'h9C40;    // 400.00 Hz
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [15:0] ONE16        = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PREEXC, ST_ACC_REL, ST_WAIT_CUR, ST_REL_HOLD, ST_RUN,
    ST_DECEL, ST_ENG_HOLD, ST_DC_BRAKE, ST_PLAIN_STOP
  } bcs_state_t;

  typedef struct packed {
    logic accel_en;    // ramp toward commanded or target frequency
    logic decel_en;    // ramp downward
    logic hold_freq;   // freeze output frequency
    logic force_zero;  // output frequency forced to 0
    logic pre_excite;  // vector pre-excitation
    logic dc_brake;    // dc injection after engage hold
    logic out_block;   // inverter output cut off
  } bcs_drive_t;

  localparam bcs_drive_t DRV_BLOCK = '{default: 1'b0, out_block: 1'b1};

endpackage : bcs_pkg

// ===== bench/bcs_brake_seq_monitor.sv
// Purpose: port-level checker for the brake control sequencer
// Assumes: registered outputs, one clock domain
// Notes:   register contents are not shadowed, so checks tie outputs together
`timescale 1ns/1ps
`default_nettype none
module bcs_brake_seq_monitor
  import bcs_pkg::*;
(
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          wr_stb,
  input wire logic          rd_stb,
  input wire logic [DW-1:0] rdata,
  input wire logic          run_cmd,
  input wire logic          dir_reverse,
  input wire logic [15:0]   out_freq,
  input wire logic [15:0]   motor_current,
  input wire bcs_drive_t    drive_cmd,
  input wire logic [15:0]   freq_target,
  input wire logic          relay_one,
  input wire logic          relay_two,
  input wire logic          transistor_output_one,
  input wire logic          suppress_dc_start,
  input wire logic          suppress_dwell
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_suppress_pair: assert property (suppress_dc_start == suppress_dwell)
    else $error("suppress outputs disagree");
  a_suppress_follow: assert property
    (wr_stb && addr == ADDR_CTRL |-> ##2 suppress_dwell == $past(wdata[CTRL_EN_BIT], 2))
    else $error("suppress does not follow brake enable");
  a_release_cause: assert property ($rose(relay_one) |-> $past(drive_cmd.hold_freq))
    else $error("release without a preceding hold");
  a_release_hold: assert property ($rose(relay_one) |-> drive_cmd.hold_freq && !drive_cmd.accel_en)
    else $error("acceleration at release");
  a_engage_freq: assert property ($fell(relay_one) |-> $past(out_freq) <= $past(freq_target))
    else $error("engage above engage frequency");
  a_engage_hold: assert property ($fell(relay_one) |-> drive_cmd.hold_freq || drive_cmd.out_block)
    else $error("no hold after engage");
  a_zero_after_hold: assert property ($rose(drive_cmd.force_zero) |-> $past(drive_cmd.hold_freq) && !relay_one)
    else $error("zero forced outside engage hold");
  a_dc_zero: assert property (drive_cmd.dc_brake |-> drive_cmd.force_zero && !relay_one)
    else $error("dc braking with frequency or released brake");
  a_dc_then_block: assert property ($fell(drive_cmd.dc_brake) |-> drive_cmd.out_block)
    else $error("output not blocked after dc braking");
  a_block_engaged: assert property (drive_cmd.out_block |-> !(relay_one || relay_two || transistor_output_one))
    else $error("brake released while output blocked");

  c_vector_release: cover property ($rose(relay_one) && $past(drive_cmd.pre_excite));
  c_dc_brake: cover property ($rose(drive_cmd.dc_brake));
  c_torque_stop: cover property ($fell(relay_one) && drive_cmd.out_block);
endmodule : bcs_brake_seq_monitor
`default_nettype wire

// ===== bench/bcs_motor_model.sv
// Purpose: motor and load behind the brake sequencer
// Assumes: frequency ramps by STEP per cycle up to FMAX
// Notes:   current follows the bench level, zero while output is blocked
`timescale 1ns/1ps
`default_nettype none
module bcs_motor_model
  import bcs_pkg::*;
#(
  parameter logic [15:0] STEP = 16'h0028,
  parameter logic [15:0] FMAX = 16'h0fa0
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire bcs_drive_t  drive_cmd,
  input  wire logic [15:0] cur_in,
  output logic      [15:0] out_freq,
  output logic      [15:0] motor_current
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      out_freq <= 16'h0000;
    else if (drive_cmd.force_zero || drive_cmd.out_block)
      out_freq <= 16'h0000;
    else if (drive_cmd.hold_freq || drive_cmd.pre_excite)
      out_freq <= out_freq;
    else if (drive_cmd.accel_en && out_freq < FMAX)
      out_freq <= out_freq + STEP;
    else if (drive_cmd.decel_en)
      out_freq <= (out_freq > STEP) ? out_freq - STEP : 16'h0000;
  end
  // no torque without output, so a nonzero release current can never be met then
  assign motor_current = drive_cmd.out_block ? 16'h0000 : cur_in;
endmodule : bcs_motor_model
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for the brake control sequencer
// Assumes: one delay tick shortened to TK cycles
// Notes:   expectations come from package defaults and written settings
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcs_pkg::*;
  localparam int TK = 4;
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wdata = 32'h0000_0000;
  logic          wr_stb = 1'b0;
  logic          rd_stb = 1'b0;
  logic          run_cmd = 1'b0;
  logic          dir_reverse = 1'b0;
  logic [15:0]   cur_in = 16'h0000;
  logic [DW-1:0] rdata;
  logic [15:0]   out_freq;
  logic [15:0]   motor_current;
  bcs_drive_t    drive_cmd;
  logic [15:0]   freq_target;
  logic          relay_one;
  logic          relay_two;
  logic          transistor_output_one;
  logic          suppress_dc_start;
  logic          suppress_dwell;
  int            num_errors = 0;
  int            checked = 0;
  logic [31:0]   d;
  logic [7:0]    ra [7] = '{ADDR_REL_CURR, ADDR_REL_DLY, ADDR_REL_FWD, ADDR_REL_REV, ADDR_ENG_DLY, ADDR_ENG_FREQ, 8'h30};
  logic [15:0]   rv [7] = '{REL_CURR_RST, REL_DLY_RST, REL_FRQ_RST, REL_FRQ_RST, ENG_DLY_RST, ENG_FRQ_RST, 16'h0000};

  always #25 clk = ~clk;

  bcs_brake_seq #(.TICK_CYC(TK)) dut (.clk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .run_cmd,
    .dir_reverse, .out_freq, .motor_current, .drive_cmd, .freq_target, .relay_one, .relay_two,
    .transistor_output_one, .suppress_dc_start, .suppress_dwell);
  bcs_motor_model motor (.clk, .arst_n, .drive_cmd, .cur_in, .out_freq, .motor_current);

  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    // idle edge so a following write never sets the strobe in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask : rd

  function automatic logic cond(input int k);
    case (k)
      0: return drive_cmd.hold_freq;
      1: return relay_one;
      2: return drive_cmd.accel_en;
      3: return !relay_one;
      4: return drive_cmd.force_zero || drive_cmd.out_block;
      default: return drive_cmd.out_block;
    endcase
  endfunction : cond

  // registered outputs are read at the edge, so every count lags by one alike
  task automatic wait_for(input int k, output int n);
    n = 0;
    while (!cond(k) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 3000, 1);
  endtask : wait_for

  task automatic seq(input logic [2:0] m, input logic tq);
    logic [7:0]  f2;
    logic [7:0]  f3;
    logic [15:0] rf;
    logic [15:0] dl;
    logic        vec;
    logic        rev;
    int          n;
    f2 = $urandom_range(1) ? FUNC_BRAKE : 8'h22;
    f3 = $urandom_range(1) ? FUNC_BRAKE : 8'h24;
    rf = 16'($urandom_range(900, 100));
    dl = 16'($urandom_range(5, 1));
    vec = (m == MODE_VECTOR);
    rev = 1'($urandom_range(1));
    dir_reverse <= rev;
    wr(ADDR_OUT_FUNC, {8'h00, f3, f2, FUNC_BRAKE});
    wr(rev ? ADDR_REL_REV : ADDR_REL_FWD, {16'h0000, rf});
    wr(ADDR_REL_DLY, {16'h0000, dl});
    wr(ADDR_ENG_DLY, {16'h0000, dl});
    wr(ADDR_DCB_TIME, (m == 3'h2) ? 32'h0000_0003 : 32'h0000_0000);
    wr(ADDR_CTRL, {27'h0, tq, m, 1'b1});
    run_cmd <= 1'b1;
    if (!vec) begin
      wait_for(0, n);
      chk(freq_target, rf);
      repeat (12) @(posedge clk);
      chk(relay_one, 1'b0);
      cur_in <= REL_CURR_RST;
    end
    wait_for(1, n);
    if (vec) chk(n >= 2 * TK && n <= 4 * TK + 3, 1);
    chk(relay_two, f2 == FUNC_BRAKE);
    chk(transistor_output_one, f3 == FUNC_BRAKE);
    chk(suppress_dc_start && suppress_dwell, 1);
    wait_for(2, n);
    chk(n >= (dl - 1) * TK && n <= (dl + 1) * TK + 3, 1);
    repeat (60) @(posedge clk);
    run_cmd <= 1'b0;
    wait_for(3, n);
    chk(out_freq <= (vec ? 16'h0000 : ENG_FRQ_RST), 1);
    if (tq) chk(drive_cmd.out_block, 1);
    else begin
      wait_for(4, n);
      chk(n >= (dl - 1) * TK && n <= (dl + 1) * TK + 3, 1);
      if (m == 3'h2) begin
        // dc braking follows the one-cycle zero-force exit of the engage hold
        @(posedge clk);
        chk(drive_cmd.dc_brake, 1);
      end
    end
    wait_for(5, n);
    cur_in <= 16'h0000;
  endtask : seq

  initial begin
    void'($urandom(32'h037e));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk(32'(drive_cmd), 32'(DRV_BLOCK));
    chk({relay_one, relay_two, transistor_output_one}, 3'h0);
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk(d, {16'h0000, rv[i]});
    end
    wr(ADDR_REL_CURR, 32'h0000_ffff);
    rd(ADDR_REL_CURR, d);
    chk(d, {16'h0000, REL_CURR_MAX});
    wr(ADDR_REL_CURR, {16'h0000, REL_CURR_RST});
    wr(ADDR_CTRL, 32'h0000_000e);
    rd(ADDR_CTRL, d);
    chk(d[3:1], MODE_MAX);
    wr(ADDR_PREEXC, 32'h0000_0003);
    wr(ADDR_DCB_LVL, 32'h0000_0005);
    for (int m = 0; m < 6; m++) seq(3'(m), 1'b0);
    seq(MODE_VECTOR, 1'b1);
    results();
  end

  // seven sequences need under two thousand cycles; twenty times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : testbench

bind bcs_brake_seq bcs_brake_seq_monitor u_mon (.clk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .run_cmd, .dir_reverse, .out_freq, .motor_current, .drive_cmd, .freq_target, .relay_one, .relay_two,
  .transistor_output_one, .suppress_dc_start, .suppress_dwell);
`default_nettype wire
